// [common/lane_cfg_pkg.sv]
package lane_cfg_pkg;

    // ************************************************************
    // Register indices; byte address is four times the index.
    // ************************************************************
    localparam logic [11:0] PAIR_EN_IDX = 12'h209;
    localparam logic [11:0] SHM_IDX     = 12'h20f;
    localparam logic [11:0] CTRL_IDX    = 12'h200;
    localparam logic [11:0] STAT_IDX    = 12'h201;

    // ************************************************************
    // Reset values and field positions.
    // ************************************************************
    localparam logic [7:0]  PAIR_EN_RST = 8'h03;
    localparam logic [7:0]  SHM_RST     = 8'h00;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam int          AB_BIT      = 0;
    localparam int          CD_BIT      = 1;
    localparam int          SINGLE_BIT  = 2;
    localparam int          LINK_EN_BIT = 0;
    localparam int          CAL_EN_BIT  = 1;
    localparam int          MODE66_BIT  = 2;

    // ************************************************************
    // Sync-header encodings and sizes.
    // ************************************************************
    localparam logic [1:0]  SHM_CRC12   = 2'h0;
    localparam logic [1:0]  SHM_FEC     = 2'h2;
    localparam int          SYNC_W      = 32;
    localparam int          CRC_W       = 12;
    localparam int          FEC_W       = 26;
    localparam int          SAMPLE_W    = 9;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          FULL_LANES  = 8;
    localparam int          FULL_CONV   = 4;

endpackage

// [rtl/jesd_channel_lane_config.sv]
`timescale 1ns/100ps

// ************************************************************
// Sample FIFO.
// ************************************************************
module sample_fifo #(
    parameter int W = 36,
    parameter int D = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;
    logic         full;
    logic         empty;

    assign empty     = wr_ptr_reg == rd_ptr_reg;
    assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                       (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // Storage has no reset, so only the pointers say which words are valid.
    always_ff @(posedge pclk) begin
        if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

// ************************************************************
// Channel and lane configuration with frame remapping.
// ************************************************************
module jesd_channel_lane_config
    import lane_cfg_pkg::*;
#(
    parameter int SW    = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int LANES = FULL_LANES,
    parameter int CONV  = FULL_CONV
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [13:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [4*SW-1:0] in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [4*SW-1:0]    out_data,
    input  wire logic [CRC_W-1:0] crc12_in,
    input  wire logic [FEC_W-1:0] fec_in,
    output logic [SYNC_W-1:0]  sync_word,
    output logic [3:0]         channel_active,
    output logic [3:0]         lane_count,
    output logic [3:0]         converter_count,
    output logic               tail_pad,
    output logic               link_enable,
    output logic               cal_enable
);
    logic [7:0]        channel_pair_enable_reg;
    logic [7:0]        sync_header_select_reg;
    logic [7:0]        ctrl_reg;
    logic [31:0]       prdata_reg;
    logic              err_reg;
    logic              fifo_valid;
    logic              fifo_ready;
    logic [4*SW-1:0]   fifo_data;
    logic              out_valid_reg;
    logic [4*SW-1:0]   out_data_reg;
    logic [SYNC_W-1:0] sync_word_reg;
    logic [3:0]        chan_next;
    logic [3:0]        chan_reg;
    logic [3:0]        lanes_next;
    logic [3:0]        conv_next;
    logic [3:0]        lanes_reg;
    logic [3:0]        conv_reg;
    logic              tail_reg;
    logic              pair_ab_enable;
    logic              pair_cd_enable;
    logic              single_channel_select;
    logic              half_cfg;
    logic              mode_66;
    logic              setup;
    logic              access;

    function automatic logic hit(input logic [13:0] a, input logic [11:0] i);
        return a[13:2] == i && a[1:0] == 2'b00;
    endfunction

    assign pair_ab_enable        = channel_pair_enable_reg[AB_BIT];
    assign pair_cd_enable        = channel_pair_enable_reg[CD_BIT];
    assign single_channel_select = channel_pair_enable_reg[SINGLE_BIT];
    assign link_enable           = ctrl_reg[LINK_EN_BIT];
    assign cal_enable            = ctrl_reg[CAL_EN_BIT];
    assign mode_66               = ctrl_reg[MODE66_BIT];
    assign setup                 = psel && !penable;
    assign access                = psel && penable;

    // ************************************************************
    // APB slave: registered read data, no wait states.
    // ************************************************************
    assign pready  = 1'b1;
    assign pslverr = access && err_reg;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else if (setup) begin
            err_reg    <= !(hit(paddr, PAIR_EN_IDX) || hit(paddr, SHM_IDX) ||
                            hit(paddr, CTRL_IDX) || hit(paddr, STAT_IDX));
            prdata_reg <= 32'h0000_0000;
            if (hit(paddr, PAIR_EN_IDX)) begin
                prdata_reg[7:0] <= channel_pair_enable_reg;
            end
            if (hit(paddr, SHM_IDX)) begin
                prdata_reg[7:0] <= sync_header_select_reg;
            end
            if (hit(paddr, CTRL_IDX)) begin
                prdata_reg[7:0] <= ctrl_reg;
            end
            if (hit(paddr, STAT_IDX)) begin
                prdata_reg[12:0] <= {tail_reg, conv_reg, lanes_reg,
                                     chan_reg};
            end
        end
    end

    // The status word is read-only, so a write there is simply dropped.
    // Reserved bits are stored as written; software keeps them zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_pair_enable_reg <= PAIR_EN_RST;
            sync_header_select_reg  <= SHM_RST;
            ctrl_reg                <= CTRL_RST;
        end else if (access && pwrite && !err_reg) begin
            if (hit(paddr, PAIR_EN_IDX)) begin
                channel_pair_enable_reg <= pwdata[7:0];
            end
            if (hit(paddr, SHM_IDX)) begin
                sync_header_select_reg <= pwdata[7:0];
            end
            if (hit(paddr, CTRL_IDX)) begin
                ctrl_reg <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Channel, lane and converter scaling.
    // ************************************************************
    // Single-channel mode runs on channel A alone, so it scales the
    // link as half a configuration with one converter.
    always_comb begin
        half_cfg   = single_channel_select ||
                     (pair_ab_enable != pair_cd_enable);
        chan_next  = {pair_cd_enable, pair_cd_enable,
                      pair_ab_enable, pair_ab_enable};
        lanes_next = 4'(LANES);
        conv_next  = 4'(CONV);
        if (single_channel_select) begin
            chan_next = 4'b0001;
        end
        if (half_cfg) begin
            lanes_next = 4'((LANES + 1) / 2);
            conv_next  = 4'(CONV / 2);
        end
        if (single_channel_select) begin
            conv_next = 4'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_reg  <= 4'hf;
            lanes_reg <= 4'(LANES);
            conv_reg  <= 4'(CONV);
            tail_reg  <= 1'b0;
        end else begin
            chan_reg  <= chan_next;
            lanes_reg <= lanes_next;
            conv_reg  <= conv_next;
            tail_reg  <= half_cfg && (LANES % 2 == 1);
        end
    end

    assign channel_active  = chan_reg;
    assign lane_count      = lanes_reg;
    assign converter_count = conv_reg;
    assign tail_pad        = tail_reg;

    // ************************************************************
    // Frame path: FIFO, remap and output stage.
    // ************************************************************
    // Frames stall while the link is off, so the FIFO fills and
    // in_ready falls back to the sample source.
    sample_fifo #(
        .W (4*SW),
        .D (DEPTH)
    ) sample_fifo_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    assign fifo_ready = link_enable && (!out_valid_reg || out_ready);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            if (fifo_ready) begin
                out_valid_reg <= fifo_valid;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
            if (fifo_ready && fifo_valid) begin
                out_data_reg <= '0;
                if (single_channel_select) begin
                    out_data_reg[SW-1:0] <= fifo_data[SW-1:0];
                end else if (!pair_ab_enable) begin
                    out_data_reg[2*SW-1:0] <= fifo_data[4*SW-1:2*SW];
                end else if (!pair_cd_enable) begin
                    out_data_reg[2*SW-1:0] <= fifo_data[2*SW-1:0];
                end else begin
                    out_data_reg <= fifo_data;
                end
            end
        end
    end

    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    // ************************************************************
    // Sync word with command fields held at idle.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_word_reg <= 32'h0000_0000;
        end else if (!mode_66) begin
            sync_word_reg <= 32'h0000_0000;
        end else if (sync_header_select_reg[1:0] == SHM_CRC12) begin
            sync_word_reg <= {{(SYNC_W-CRC_W){1'b0}}, crc12_in};
        end else if (sync_header_select_reg[1:0] == SHM_FEC) begin
            sync_word_reg <= {{(SYNC_W-FEC_W){1'b0}}, fec_in};
        end else begin
            sync_word_reg <= 32'h0000_0000;
        end
    end

    assign sync_word = sync_word_reg;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    single_only_a_a: assert property (
        single_channel_select |=> channel_active == 4'b0001)
        else $error("single channel mode left B, C or D on");
    cd_pair_a: assert property (
        !single_channel_select |=>
        channel_active[3:2] == {2{$past(pair_cd_enable)}})
        else $error("C/D enables do not follow bit 1");
    ab_pair_a: assert property (
        !single_channel_select |=>
        channel_active[1:0] == {2{$past(pair_ab_enable)}})
        else $error("A/B enables do not follow bit 0");
    half_lanes_a: assert property (
        (pair_ab_enable ^ pair_cd_enable) && !single_channel_select |=>
        lane_count == 4'((LANES + 1) / 2) && converter_count == 4'(CONV / 2))
        else $error("lane or converter count not halved");
    tail_pad_a: assert property (
        ##1 tail_pad == ($past(half_cfg) && (LANES % 2 == 1)))
        else $error("tail padding wrong");
    remap_cd_a: assert property (
        fifo_ready && fifo_valid && !pair_ab_enable && !single_channel_select
        |=> out_data[2*SW-1:0] == $past(fifo_data[4*SW-1:2*SW]))
        else $error("C/D samples not moved to A/B slots");
    shm_crc_a: assert property (
        mode_66 && sync_header_select_reg[1:0] == SHM_CRC12 |=>
        sync_word[CRC_W-1:0] == $past(crc12_in))
        else $error("CRC-12 not sent");
    mode_gate_a: assert property (
        !mode_66 |=> sync_word == 32'h0000_0000)
        else $error("sync word sent outside 64B/66B");
    cmd_idle_a: assert property (
        mode_66 && sync_header_select_reg[1:0] == SHM_CRC12 |=>
        sync_word[SYNC_W-1:CRC_W] == '0)
        else $error("command field not idle");
    shm_fec_a: assert property (
        mode_66 && sync_header_select_reg[1:0] == SHM_FEC |=>
        sync_word == {{(SYNC_W-FEC_W){1'b0}}, $past(fec_in)})
        else $error("FEC word not sent");
    shm_rsv_a: assert property (
        sync_header_select_reg[0] |=> sync_word == 32'h0000_0000)
        else $error("reserved sync mode not idle");
    single_conv_a: assert property (
        single_channel_select |=>
        converter_count == 4'd1 && lane_count == 4'((LANES + 1) / 2))
        else $error("single channel scaling wrong");
endmodule

// [sim/frame_sink.sv]
`timescale 1ns/100ps

// ************************************************************
// Receiving end of the frame stream, with an optional stall.
// ************************************************************
module frame_sink #(
    parameter int W = 36
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         slow,
    input  wire logic         out_valid,
    input  wire logic [W-1:0] out_data,
    output logic              out_ready
);
    logic [W-1:0] q[$];
    logic         ph;

    // Slow mode takes one frame every other cycle to back up the FIFO.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph        <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            ph        <= ~ph;
            out_ready <= slow ? ph : 1'b1;
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                q.push_back(out_data);
            end
        end
    end
endmodule

// [sim/jesd_channel_lane_config_tb.sv]
`timescale 1ns/100ps

module jesd_channel_lane_config_tb;
    import lane_cfg_pkg::*;

    // ************************************************************
    // Signals.
    // ************************************************************
    localparam int LN = 7;
    localparam int HL = (LN + 1) / 2;
    logic          pclk, presetn, psel, penable, pwrite;
    logic [13:0]   paddr;
    logic [31:0]   pwdata, prdata, rdv;
    logic          pready, pslverr, erv, slow;
    logic          in_valid, in_ready, out_valid, out_ready;
    logic [35:0]   in_data, out_data;
    logic [CRC_W-1:0] crc12_in;
    logic [FEC_W-1:0] fec_in;
    logic [SYNC_W-1:0] sync_word;
    logic [3:0]    channel_active, lane_count, converter_count;
    logic          tail_pad, link_enable, cal_enable;
    logic [7:0]    modes[4] = '{8'h03, 8'h01, 8'h02, 8'h05};
    logic [12:0]   cfg_exp[4];
    int            n_fail, checked, cyc, n;

    // The odd lane count makes tail padding visible.
    jesd_channel_lane_config #(.LANES(LN)) jesd_channel_lane_config_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .crc12_in(crc12_in),
        .fec_in(fec_in), .sync_word(sync_word),
        .channel_active(channel_active), .lane_count(lane_count),
        .converter_count(converter_count), .tail_pad(tail_pad),
        .link_enable(link_enable), .cal_enable(cal_enable));

    frame_sink #(.W(36)) frame_sink_inst (
        .pclk(pclk), .presetn(presetn), .slow(slow),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    // ************************************************************
    // Tasks.
    // ************************************************************
    task automatic stop_test;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [13:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    function automatic logic [35:0] frame(input int k);
        frame = {9'(4*k+3), 9'(4*k+2), 9'(4*k+1), 9'(4*k)};
    endfunction

    function automatic logic [35:0] remap(input logic [7:0] m,
                                          input logic [35:0] f);
        case (m)
            8'h01:   remap = {18'h0_0000, f[17:0]};
            8'h02:   remap = {18'h0_0000, f[35:18]};
            8'h05:   remap = {27'h000_0000, f[8:0]};
            default: remap = f;
        endcase
    endfunction

    task automatic wait_frames(input int k);
        for (int t = 0; t < 300 && frame_sink_inst.q.size() < k; t++) begin
            @(posedge pclk);
        end
    endtask

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        {psel, penable, pwrite, in_valid, slow} = '0;
        paddr = '0;
        pwdata = '0;
        in_data = '0;
        crc12_in = 12'ha5c;
        fec_in = 26'h2ab_cdef;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        cfg_exp = '{{1'b0, 4'(FULL_CONV), 4'(LN), 4'hf},
                    {1'b1, 4'(FULL_CONV/2), 4'(HL), 4'h3},
                    {1'b1, 4'(FULL_CONV/2), 4'(HL), 4'hc},
                    {1'b1, 4'h1, 4'(HL), 4'h1}};
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 14'h0824, '0);
        chk(rdv, 32'h0000_0003);
        apb(1'b0, 14'h083c, '0);
        chk(rdv, 32'h0000_0000);
        apb(1'b0, 14'h0900, '0);
        chk(erv, 1'b1);
        wr(14'h0900, 32'h0000_0001);
        chk(erv, 1'b1);
        wr(14'h0804, 32'h0000_ffff);
        apb(1'b0, 14'h0804, '0);
        chk(rdv, {19'h0_0000, cfg_exp[0]});
        wr(14'h0800, 32'h0000_0002);
        apb(1'b0, 14'h0800, '0);
        chk(rdv, 32'h0000_0002);
        chk({cal_enable, link_enable}, 2'b10);
        for (int i = 0; i < 4; i++) begin
            wr(14'h0800, 32'h0000_0000);
            wr(14'h0824, {24'h00_0000, modes[i]});
            repeat (2) @(posedge pclk);
            chk({tail_pad, converter_count, lane_count, channel_active},
                cfg_exp[i]);
            chk({cal_enable, link_enable}, 2'b00);
            apb(1'b0, 14'h0804, '0);
            chk(rdv, {19'h0_0000, cfg_exp[i]});
            apb(1'b0, 14'h0824, '0);
            chk(rdv, {24'h00_0000, modes[i]});
            wr(14'h0800, 32'h0000_0001);
            frame_sink_inst.q.delete();
            @(posedge pclk);
            in_valid <= 1'b1;
            in_data  <= frame(i + 20);
            @(posedge pclk);
            while (in_ready !== 1'b1) @(posedge pclk);
            in_valid <= 1'b0;
            wait_frames(1);
            chk(frame_sink_inst.q[0], remap(modes[i], frame(i + 20)));
        end
        for (int s = 0; s < 5; s++) begin
            wr(14'h0800, 32'h0000_0000);
            wr(14'h083c, 32'(s % 4));
            wr(14'h0800, (s < 4) ? 32'h0000_0004 : 32'h0000_0000);
            repeat (3) @(posedge pclk);
            chk(sync_word, (s == 0) ? {20'h0_0000, crc12_in} :
                (s == 2) ? {6'h00, fec_in} : 32'h0000_0000);
        end
        wr(14'h0800, 32'h0000_0000);
        wr(14'h0824, 32'h0000_0003);
        frame_sink_inst.q.delete();
        slow <= 1'b1;
        in_valid <= 1'b1;
        in_data  <= frame(0);
        n = 0;
        repeat (24) begin
            @(posedge pclk);
            if (in_ready === 1'b1) begin
                n = n + 1;
                in_data <= frame(n);
            end
        end
        in_valid <= 1'b0;
        chk(n, FIFO_DEPTH);
        wr(14'h0800, 32'h0000_0001);
        wait_frames(16);
        chk(frame_sink_inst.q.size(), 16);
        for (int i = 0; i < 16 && i < frame_sink_inst.q.size(); i++) begin
            chk(frame_sink_inst.q[i], frame(i));
        end
        stop_test();
    end
endmodule
